/* hdl/cpm_flag_unit.sv */
// arithmetic result and condition flag generation
`timescale 1ns/10ps
module cpm_flag_unit (
  cpm_flag_if.alu fi
);
  import cpm_pkg::*;

  function automatic logic [31:0] sz_mask(input cpm_size_t s);
    case (s)
      CPM_SZ_BYTE: sz_mask = 32'h0000_00FF;
      CPM_SZ_WORD: sz_mask = 32'h0000_FFFF;
      default:     sz_mask = 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic msb_of(input logic [32:0] v, input cpm_size_t s);
    case (s)
      CPM_SZ_BYTE: msb_of = v[7];
      CPM_SZ_WORD: msb_of = v[15];
      default:     msb_of = v[31];
    endcase
  endfunction

  function automatic logic carry_of(input logic [32:0] v, input cpm_size_t s);
    case (s)
      CPM_SZ_BYTE: carry_of = v[8];
      CPM_SZ_WORD: carry_of = v[16];
      default:     carry_of = v[32];
    endcase
  endfunction

  logic [32:0] ma;
  logic [32:0] mb;
  logic [32:0] sum;
  logic        cin;
  logic        sub;
  logic        sa;
  logic        sb;
  logic        sr;

  always_comb begin
    ma  = {1'b0, fi.a & sz_mask(fi.size)};
    mb  = {1'b0, fi.b & sz_mask(fi.size)};
    cin = (fi.op == CPM_OP_ADDX || fi.op == CPM_OP_SUBX) ? fi.x_in : 1'b0;
    sub = (fi.op == CPM_OP_SUB || fi.op == CPM_OP_SUBX);
    if (fi.op == CPM_OP_LOGIC) begin
      sum = mb;
    end else if (sub) begin
      sum = ma - mb - {32'h0, cin};
    end else begin
      sum = ma + mb + {32'h0, cin};
    end
    sa     = msb_of(ma, fi.size);
    sb     = msb_of(mb, fi.size);
    sr     = msb_of(sum, fi.size);
    fi.res = sum[31:0];
    fi.flags[CPM_CC_N] = sr;
    fi.flags[CPM_CC_Z] = ((sum[31:0] & sz_mask(fi.size)) == 32'h0);
    if (fi.op == CPM_OP_LOGIC) begin
      fi.flags[CPM_CC_V] = 1'b0;
      fi.flags[CPM_CC_C] = 1'b0;
      fi.flags[CPM_CC_X] = fi.x_in;
    end else begin
      fi.flags[CPM_CC_V] = sub ? (sa != sb) && (sr != sa) : (sa == sb) && (sr != sa);
      fi.flags[CPM_CC_C] = carry_of(sum, fi.size);
      fi.flags[CPM_CC_X] = carry_of(sum, fi.size);
    end
  end
endmodule

/* hdl/cpm_regs.sv */
// core programming model register file with debug port access
// Functional notes
// - eight data registers, byte/word/long sized writes
// - two stack pointers, privilege selects active one
// - dual stacks only when enable set; reset clears
// - debug reads/writes active and inactive stack pointer
// - privileged user stack moves; others use active
// - reset loads supervisor stack from location zero
// - flag byte is status low byte; extend feeds carry
// - extend copies carry on arithmetic operations
// - negative flag follows result sign bit
// - zero flag set when result is zero
// - overflow flag set on signed overflow
// - carry flag on carry out or borrow
// - instruction pointer advances, reloads, bases relative addressing
// - reset loads instruction pointer from location four
// - exception base low twenty bits zero; vector adds
// - supervisor writes whole status; user only flags
// - trace bit requests trace after each instruction
// - bit thirteen selects privilege and stack pointer
// - interrupt entry clears master bit; software sets
// - mask blocks levels not above it; edge seven exempt
`timescale 1ns/10ps
module cpm_regs (
  input  wire logic            ref_clk,
  input  wire logic            arst_n,
  output logic                 fetch_req_r,
  output logic [31:0]          fetch_addr_r,
  input  wire logic            fetch_valid,
  input  wire logic [31:0]     fetch_data,
  input  wire logic [3:0]      rd_a_idx,
  input  wire logic [3:0]      rd_b_idx,
  output logic [31:0]          rd_a_data_r,
  output logic [31:0]          rd_b_data_r,
  input  wire logic            wr_en,
  input  wire logic [3:0]      wr_idx,
  input  wire cpm_pkg::cpm_size_t wr_size,
  input  wire logic [31:0]     wr_data,
  input  wire logic            alu_en,
  input  wire cpm_pkg::cpm_op_t alu_op,
  input  wire cpm_pkg::cpm_size_t alu_size,
  input  wire logic [3:0]      alu_dst,
  input  wire logic [31:0]     alu_a,
  input  wire logic [31:0]     alu_b,
  input  wire logic            usp_wr,
  input  wire logic [31:0]     usp_wdata,
  output logic [31:0]          usp_data_r,
  input  wire logic            sr_wr,
  input  wire logic [15:0]     sr_wdata,
  input  wire logic            ccr_wr,
  input  wire logic            cache_control_word_wr,
  input  wire logic            vbr_wr,
  input  wire logic [31:0]     ctl_wdata,
  output logic [15:0]          status_r,
  input  wire logic            exc_enter,
  input  wire logic            exc_irq,
  input  wire logic [2:0]      exc_lvl,
  input  wire logic [9:0]      vec_disp,
  output logic [31:0]          vec_addr_r,
  input  wire logic            pc_adv,
  input  wire logic [2:0]      pc_step,
  input  wire logic            pc_load,
  input  wire logic [31:0]     pc_new,
  input  wire logic [31:0]     pcrel_disp,
  output logic [31:0]          pc_r,
  output logic [31:0]          pcrel_addr_r,
  input  wire logic            instr_done,
  output logic                 trace_req_r,
  input  wire logic [2:0]      irq_lvl,
  input  wire logic            irq_edge7,
  output logic                 irq_take_r,
  input  wire logic            dbg_req,
  input  wire logic            dbg_wr,
  input  wire logic [11:0]     dbg_rc,
  input  wire logic [31:0]     dbg_wdata,
  output logic [31:0]          dbg_rdata_r,
  output logic                 dbg_ack_r,
  output logic                 dbg_err_r
);
  import cpm_pkg::*;

  logic [31:0] gp_r [0:14];
  logic [31:0] ssp_r;
  logic [31:0] usp_r;
  logic [31:0] cache_control_word_r;
  logic [11:0] vbr_r;
  logic [15:0] sr_r;
  cpm_fetch_t  fst_r;
  logic        sup;
  logic        dual;
  logic        act_is_ssp;
  logic [31:0] act_sp;
  logic [31:0] oth_sp;
  logic [31:0] vbr_full;
  logic        dbg_w;
  logic        dbg_gp;
  logic [3:0]  dbg_idx;
  logic        gp_we;
  logic [3:0]  gp_idx;
  logic [31:0] gp_val;
  logic        sr_busy;

  cpm_flag_if fif ();
  cpm_flag_unit u_flags (.fi(fif));

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input cpm_size_t s, input logic is_addr);
    if (is_addr) begin
      merge = (s == CPM_SZ_WORD) ? {{16{nv[15]}}, nv[15:0]} : nv;
    end else begin
      case (s)
        CPM_SZ_BYTE: merge = {old[31:8], nv[7:0]};
        CPM_SZ_WORD: merge = {old[31:16], nv[15:0]};
        default:     merge = nv;
      endcase
    end
  endfunction

  function automatic logic [31:0] reg_rd(input logic [3:0] idx, input logic [31:0] sp,
                                         input logic [31:0] g);
    reg_rd = (idx == CPM_SP_IDX) ? sp : g;
  endfunction

  assign sup        = sr_r[CPM_SR_S];
  assign dual       = cache_control_word_r[CPM_DSE_BIT];
  assign act_is_ssp = sup || !dual;
  assign act_sp     = act_is_ssp ? ssp_r : usp_r;
  assign oth_sp     = act_is_ssp ? usp_r : ssp_r;
  assign vbr_full   = {vbr_r, {CPM_VBR_LO{1'b0}}};
  assign dbg_w      = dbg_req && dbg_wr;
  assign dbg_gp     = (dbg_rc[11:4] == CPM_RC_GP[11:4]);
  assign dbg_idx    = dbg_rc[3:0];
  assign sr_busy    = (dbg_w && dbg_rc == CPM_RC_SR) || exc_enter || sr_wr || ccr_wr;

  assign fif.op   = alu_op;
  assign fif.size = alu_size;
  assign fif.a    = alu_a;
  assign fif.b    = alu_b;
  assign fif.x_in = sr_r[CPM_CC_X];

  // one shared write path into the general registers, debug first
  always_comb begin
    gp_we  = 1'b0;
    gp_idx = 4'h0;
    gp_val = 32'h0;
    if (dbg_w && dbg_gp) begin
      gp_we  = 1'b1;
      gp_idx = dbg_idx;
      gp_val = dbg_wdata;
    end else if (alu_en) begin
      gp_we  = 1'b1;
      gp_idx = alu_dst;
      gp_val = merge(reg_rd(alu_dst, act_sp, gp_r[alu_dst[3:0] == CPM_SP_IDX ? 4'h0 : alu_dst]),
                     fif.res, alu_size, alu_dst[3]);
    end else if (wr_en) begin
      gp_we  = 1'b1;
      gp_idx = wr_idx;
      gp_val = merge(reg_rd(wr_idx, act_sp, gp_r[wr_idx == CPM_SP_IDX ? 4'h0 : wr_idx]),
                     wr_data, wr_size, wr_idx[3]);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 15; i++) begin
        gp_r[i] <= 32'h0;
      end
      gp_r[0] <= CPM_D0_RESET;
      gp_r[1] <= CPM_D1_RESET;
    end else if (gp_we && gp_idx != CPM_SP_IDX) begin
      gp_r[gp_idx] <= gp_val;
    end
  end

  // reset fetch of initial stack pointer and instruction pointer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fst_r        <= CPM_FS_SP;
      fetch_req_r  <= 1'b1;
      fetch_addr_r <= CPM_RST_SP_LOC;
    end else begin
      case (fst_r)
        CPM_FS_SP: begin
          if (fetch_valid) begin
            fst_r        <= CPM_FS_PC;
            fetch_addr_r <= CPM_RST_PC_LOC;
          end
        end
        CPM_FS_PC: begin
          if (fetch_valid) begin
            fst_r       <= CPM_FS_DONE;
            fetch_req_r <= 1'b0;
          end
        end
        CPM_FS_DONE: fetch_req_r <= 1'b0;
        default: fst_r <= CPM_FS_DONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ssp_r <= 32'h0;
      usp_r <= 32'h0;
    end else if (fst_r == CPM_FS_SP && fetch_valid) begin
      ssp_r <= fetch_data;
    end else if (dbg_w && dbg_rc == CPM_RC_OTHSP) begin
      if (act_is_ssp) usp_r <= dbg_wdata;
      else ssp_r <= dbg_wdata;
    end else if (gp_we && gp_idx == CPM_SP_IDX) begin
      if (act_is_ssp) ssp_r <= gp_val;
      else usp_r <= gp_val;
    end else if (usp_wr && sup) begin
      usp_r <= usp_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cache_control_word_r <= CPM_CACHE_CONTROL_WORD_RESET;
      vbr_r  <= 12'h000;
    end else if (dbg_w && dbg_rc == CPM_RC_CACHE_CONTROL_WORD) begin
      cache_control_word_r <= dbg_wdata;
    end else if (dbg_w && dbg_rc == CPM_RC_VBR) begin
      vbr_r <= dbg_wdata[31:CPM_VBR_LO];
    end else if (cache_control_word_wr && sup) begin
      cache_control_word_r <= ctl_wdata;
    end else if (vbr_wr && sup) begin
      vbr_r <= ctl_wdata[31:CPM_VBR_LO];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_r <= CPM_SR_RESET;
    end else if (dbg_w && dbg_rc == CPM_RC_SR) begin
      sr_r <= dbg_wdata[15:0] & CPM_SR_DEFINED;
    end else if (exc_enter) begin
      sr_r[CPM_SR_S] <= 1'b1;
      sr_r[CPM_SR_T] <= 1'b0;
      if (exc_irq) begin
        sr_r[CPM_SR_M] <= 1'b0;
        sr_r[CPM_SR_I_HI:CPM_SR_I_LO] <= exc_lvl;
      end
    end else if (sr_wr) begin
      if (sup) sr_r <= sr_wdata & CPM_SR_DEFINED;
      else sr_r[7:0] <= sr_wdata[7:0] & CPM_CC_DEFINED;
    end else if (ccr_wr) begin
      sr_r[7:0] <= ctl_wdata[7:0] & CPM_CC_DEFINED;
    end else if (alu_en) begin
      sr_r[4:0] <= fif.flags;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_r <= 32'h0;
    end else if (fst_r == CPM_FS_PC && fetch_valid) begin
      pc_r <= fetch_data;
    end else if (dbg_w && dbg_rc == CPM_RC_PC) begin
      pc_r <= dbg_wdata;
    end else if (pc_load) begin
      pc_r <= pc_new;
    end else if (pc_adv) begin
      pc_r <= pc_r + {29'h0, pc_step};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pcrel_addr_r <= 32'h0;
      vec_addr_r   <= 32'h0;
    end else begin
      pcrel_addr_r <= pc_r + pcrel_disp;
      vec_addr_r   <= vbr_full + {22'h0, vec_disp};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trace_req_r <= 1'b0;
      irq_take_r  <= 1'b0;
    end else begin
      trace_req_r <= instr_done && sr_r[CPM_SR_T];
      irq_take_r  <= irq_edge7 || (irq_lvl > sr_r[CPM_SR_I_HI:CPM_SR_I_LO]);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_a_data_r <= 32'h0;
      rd_b_data_r <= 32'h0;
      usp_data_r  <= 32'h0;
      status_r    <= CPM_SR_RESET;
    end else begin
      rd_a_data_r <= reg_rd(rd_a_idx, act_sp, gp_r[rd_a_idx == CPM_SP_IDX ? 4'h0 : rd_a_idx]);
      rd_b_data_r <= reg_rd(rd_b_idx, act_sp, gp_r[rd_b_idx == CPM_SP_IDX ? 4'h0 : rd_b_idx]);
      usp_data_r  <= usp_r;
      status_r    <= sr_r;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dbg_rdata_r <= 32'h0;
      dbg_ack_r   <= 1'b0;
      dbg_err_r   <= 1'b0;
    end else begin
      dbg_ack_r <= dbg_req;
      dbg_err_r <= 1'b0;
      if (dbg_req) begin
        if (dbg_gp) dbg_rdata_r <= reg_rd(dbg_idx, act_sp, gp_r[dbg_idx == CPM_SP_IDX ? 4'h0 : dbg_idx]);
        else if (dbg_rc == CPM_RC_OTHSP) dbg_rdata_r <= oth_sp;
        else if (dbg_rc == CPM_RC_SR) dbg_rdata_r <= {16'h0, sr_r};
        else if (dbg_rc == CPM_RC_PC) dbg_rdata_r <= pc_r;
        else if (dbg_rc == CPM_RC_VBR) dbg_rdata_r <= vbr_full;
        else if (dbg_rc == CPM_RC_CACHE_CONTROL_WORD) dbg_rdata_r <= cache_control_word_r;
        else begin
          dbg_rdata_r <= 32'h0;
          dbg_err_r   <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_vbr_read;
    dbg_req && !dbg_wr && dbg_rc == CPM_RC_VBR;
  endsequence
  sequence s_ack_low_zero;
    dbg_ack_r && dbg_rdata_r[19:0] == 20'h0;
  endsequence
  property p_vbr_low;
    s_vbr_read |=> s_ack_low_zero;
  endproperty
  a_vbr_low: assert property (p_vbr_low) else $error("base low bits not zero");

  property p_trace;
    instr_done && sr_r[CPM_SR_T] |=> trace_req_r ##1 (trace_req_r == $past(instr_done && sr_r[CPM_SR_T]));
  endproperty
  a_trace: assert property (p_trace) else $error("trace request missing");

  property p_irq_mask;
    !irq_edge7 && irq_lvl <= sr_r[CPM_SR_I_HI:CPM_SR_I_LO] |=> !irq_take_r;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt taken");

  property p_edge7;
    irq_edge7 |=> irq_take_r;
  endproperty
  a_edge7: assert property (p_edge7) else $error("edge level seven masked");

  property p_user_sr;
    sr_wr && !sup && !exc_enter && !(dbg_w && dbg_rc == CPM_RC_SR) |=> $stable(sr_r[15:8]);
  endproperty
  a_user_sr: assert property (p_user_sr) else $error("user wrote status upper byte");

  property p_usp_priv;
    usp_wr && !sup && !dbg_w && !gp_we && fst_r == CPM_FS_DONE |=> $stable(usp_r);
  endproperty
  a_usp_priv: assert property (p_usp_priv) else $error("user stack moved in user mode");

  property p_x_carry;
    alu_en && !sr_busy && alu_op != CPM_OP_LOGIC |=> sr_r[CPM_CC_X] == sr_r[CPM_CC_C];
  endproperty
  a_x_carry: assert property (p_x_carry) else $error("extend differs from carry");

  property p_zero;
    alu_en && !sr_busy && alu_op == CPM_OP_LOGIC && alu_b == 32'h0 |=> sr_r[CPM_CC_Z] && !sr_r[CPM_CC_N];
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_rst_pc;
    fst_r == CPM_FS_PC && fetch_valid |=> pc_r == $past(fetch_data) && !fetch_req_r;
  endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("reset pointer load wrong");

  property p_m_clear;
    exc_enter && exc_irq && !(dbg_w && dbg_rc == CPM_RC_SR) |=> !sr_r[CPM_SR_M] && sup;
  endproperty
  a_m_clear: assert property (p_m_clear) else $error("master bit not cleared");

  property p_sp_swap;
    dbg_req && !dbg_wr && dbg_rc == CPM_RC_OTHSP && dual && !sup |=> dbg_rdata_r == $past(ssp_r);
  endproperty
  a_sp_swap: assert property (p_sp_swap) else $error("inactive pointer not supervisor");
endmodule

/* pkg/cpm_flag_if.sv */
// operand and flag carrier between register file and flag unit
`timescale 1ns/10ps
interface cpm_flag_if;
  import cpm_pkg::*;
  cpm_op_t     op;
  cpm_size_t   size;
  logic [31:0] a;
  logic [31:0] b;
  logic        x_in;
  logic [31:0] res;
  logic [4:0]  flags;
  modport core (output op, size, a, b, x_in, input res, flags);
  modport alu  (input op, size, a, b, x_in, output res, flags);
endinterface

/* pkg/cpm_pkg.sv */
// constants and types for the core programming model register file
package cpm_pkg;
  typedef enum logic [2:0] {CPM_OP_ADD, CPM_OP_SUB, CPM_OP_ADDX, CPM_OP_SUBX, CPM_OP_LOGIC} cpm_op_t;
  typedef enum logic [1:0] {CPM_SZ_BYTE, CPM_SZ_WORD, CPM_SZ_LONG} cpm_size_t;
  typedef enum logic [1:0] {CPM_FS_SP, CPM_FS_PC, CPM_FS_DONE} cpm_fetch_t;

  localparam int          CPM_SR_T       = 15;
  localparam int          CPM_SR_S       = 13;
  localparam int          CPM_SR_M       = 12;
  localparam int          CPM_SR_I_LO    = 8;
  localparam int          CPM_SR_I_HI    = 10;
  localparam int          CPM_CC_X       = 4;
  localparam int          CPM_CC_N       = 3;
  localparam int          CPM_CC_Z       = 2;
  localparam int          CPM_CC_V       = 1;
  localparam int          CPM_CC_C       = 0;
  localparam logic [15:0] CPM_SR_DEFINED = 16'hB71F;
  localparam logic [15:0] CPM_SR_RESET   = 16'h2700;
  localparam logic [7:0]  CPM_CC_DEFINED = 8'h1F;

  localparam logic [31:0] CPM_D0_RESET   = 32'h1357_9BD0; // arbitrary configuration word
  localparam logic [31:0] CPM_D1_RESET   = 32'h2468_ACE0; // arbitrary configuration word
  localparam logic [31:0] CPM_CACHE_CONTROL_WORD_RESET = 32'h0000_0000;
  localparam int          CPM_DSE_BIT    = 5;
  localparam int          CPM_VBR_LO     = 20;
  localparam logic [31:0] CPM_RST_SP_LOC = 32'h0000_0000;
  localparam logic [31:0] CPM_RST_PC_LOC = 32'h0000_0004;
  localparam logic [3:0]  CPM_SP_IDX     = 4'hF;
  localparam logic [2:0]  CPM_NMI_LVL    = 3'h7;

  localparam logic [11:0] CPM_RC_GP      = 12'h080;
  localparam logic [11:0] CPM_RC_CACHE_CONTROL_WORD    = 12'h002;
  localparam logic [11:0] CPM_RC_OTHSP   = 12'h800;
  localparam logic [11:0] CPM_RC_VBR     = 12'h801;
  localparam logic [11:0] CPM_RC_SR      = 12'h80E;
  localparam logic [11:0] CPM_RC_PC      = 12'h80F;
endpackage

/* test/cpm_mem_model.sv */
// memory model answering the two reset fetches of the register file
`timescale 1ns/10ps
module cpm_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        fetch_req_r,
  input  wire logic [31:0] fetch_addr_r,
  input  wire logic [3:0]  lat,
  input  wire logic [31:0] sp_val,
  input  wire logic [31:0] pc_val,
  output logic             fetch_valid,
  output logic [31:0]      fetch_data
);
  logic [3:0] cnt_r;

  // one-cycle answer after lat idle cycles, lat plus one idle cycles after a previous answer; data scrambled outside it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_valid <= 1'b0;
      cnt_r       <= 4'h0;
      fetch_data  <= 32'h5A5A_A5A5;
    end else if (!fetch_valid && fetch_req_r && cnt_r >= lat) begin
      fetch_valid <= 1'b1;
      fetch_data  <= (fetch_addr_r == 32'h0000_0004) ? pc_val : sp_val;
    end else begin
      fetch_valid <= 1'b0;
      cnt_r       <= fetch_valid ? 4'h0 : cnt_r + 4'h1;
      fetch_data  <= ~fetch_data;
    end
  end
endmodule

/* test/testbench.sv */
// self-checking testbench for the programming model register file
`timescale 1ns/10ps
module testbench;
  import cpm_pkg::*;
  logic        ref_clk = 1'b0;
  logic        arst_n = '0, wr_en = '0, alu_en = '0, usp_wr = '0, sr_wr = '0, ccr_wr = '0, cache_control_word_wr = '0;
  logic        vbr_wr = '0, exc_enter = '0, exc_irq = '0, pc_adv = '0, pc_load = '0, instr_done = '0;
  logic        irq_edge7 = '0, dbg_req = '0, dbg_wr = '0;
  logic        fetch_req_r, fetch_valid, trace_req_r, irq_take_r, dbg_ack_r, dbg_err_r, xf;
  logic [2:0]  exc_lvl = '0, pc_step = '0, irq_lvl = '0;
  logic [3:0]  rd_a_idx = '0, rd_b_idx = '0, wr_idx = '0, alu_dst = '0, lat = '0;
  logic [9:0]  vec_disp = '0;
  logic [11:0] dbg_rc = '0;
  logic [15:0] sr_wdata = '0;
  logic [15:0] status_r;
  logic [31:0] wr_data = '0, alu_a = '0, alu_b = '0, usp_wdata = '0, ctl_wdata = '0, pc_new = '0;
  logic [31:0] pcrel_disp = '0, dbg_wdata = '0, sp_val = '0, pc_val = '0;
  logic [31:0] fetch_addr_r, fetch_data, rd_a_data_r, rd_b_data_r, usp_data_r, vec_addr_r, pc_r;
  logic [31:0] pcrel_addr_r, dbg_rdata_r, rv, a, b;
  logic [31:0] gp[8];
  logic [36:0] e;
  logic [4:0]  m5;
  cpm_size_t   wr_size = CPM_SZ_BYTE, alu_size = CPM_SZ_BYTE;
  cpm_op_t     alu_op = CPM_OP_ADD;
  int          num_errors = 0, cmp_count = 0, seed = 11251, k, s, d;

  always #5 ref_clk = ~ref_clk;

  cpm_regs dut (.*);
  cpm_mem_model mem (.*);

  task automatic chk(string nm, logic [31:0] ex, logic [31:0] g);
    cmp_count++;
    if (g !== ex) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic chk_bit(string nm, logic ex, logic g);
    cmp_count++;
    if (g !== ex) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, ex, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic dbg(logic w, logic [11:0] rc, logic [31:0] wd);
    @(posedge ref_clk);
    dbg_req   <= 1'b1;
    dbg_wr    <= w;
    dbg_rc    <= rc;
    dbg_wdata <= wd;
    @(posedge ref_clk);
    dbg_req <= 1'b0;
    cyc(0);
    rv = dbg_rdata_r;
    chk_bit("dbg_ack", 1'b1, dbg_ack_r);
  endtask

  task automatic sr(logic [15:0] v);
    @(posedge ref_clk);
    sr_wr    <= 1'b1;
    sr_wdata <= v;
    @(posedge ref_clk);
    sr_wr <= 1'b0;
    cyc(1);
  endtask

  task automatic rst_fetch(logic [3:0] l);
    sp_val = $random(seed);
    pc_val = $random(seed);
    lat = l;
    arst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 40 && fetch_req_r !== 1'b0; i++) cyc(1);
    cyc(2);
    chk("pc_reset", pc_val, pc_r);
    chk("fetch_addr", CPM_RST_PC_LOC, fetch_addr_r);
    chk("sr_reset", {16'h0000, CPM_SR_RESET}, {16'h0000, status_r});
    dbg(1'b0, CPM_RC_GP | 12'h00F, 32'h0000_0000);
    chk("ssp_reset", sp_val, rv);
    dbg(1'b0, CPM_RC_CACHE_CONTROL_WORD, 32'h0000_0000);
    chk_bit("dse_reset", 1'b0, rv[CPM_DSE_BIT]);
    gp = '{CPM_D0_RESET, CPM_D1_RESET, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    xf = 1'b0;
  endtask

  // expected {x,n,z,v,c,result} of one flag unit operation
  function automatic logic [36:0] model(int op, int sz, logic [31:0] x1, logic [31:0] x2, logic xi);
    logic [32:0] m, r;
    int          hb;
    logic        ci, c, v;
    hb = (sz == 0) ? 7 : (sz == 1) ? 15 : 31;
    m = (33'h1 << (hb + 1)) - 33'h1;
    ci = (op == 2 || op == 3) ? xi : 1'b0;
    if (op == 4)
      r = {1'b0, x2} & m;
    else if (op == 0 || op == 2)
      r = ({1'b0, x1} & m) + ({1'b0, x2} & m) + {32'h0, ci};
    else
      r = ({1'b0, x1} & m) - ({1'b0, x2} & m) - {32'h0, ci};
    c = r[hb + 1];
    v = (op == 0 || op == 2) ? (x1[hb] == x2[hb] && r[hb] != x1[hb]) : (x1[hb] != x2[hb] && r[hb] != x1[hb]);
    r = r & m;
    return {(op == 4) ? xi : c, r[hb], r == 33'h0, v, c, r[31:0]};
  endfunction

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    conclude();
  end

  initial begin
    rst_fetch(4'h0);
    $display("test reset done");
    for (int i = 0; i < 30; i++) begin
      k = $unsigned($random(seed)) % 5;
      s = $unsigned($random(seed)) % 3;
      d = $unsigned($random(seed)) % 8;
      a = $random(seed);
      b = $random(seed);
      case (i)
        0: begin k = 0; s = 0; a = 32'hFF; b = 32'h01; end
        1: begin k = 1; s = 2; a = 32'h0; b = 32'h1; end
        2: begin k = 2; s = 0; a = 32'h7F; b = 32'h0; end
        3: begin k = 4; s = 1; b = 32'h0; end
        default: ;
      endcase
      e = model(k, s, a, b, xf);
      @(posedge ref_clk);
      alu_en   <= 1'b1;
      alu_op   <= cpm_op_t'(k);
      alu_size <= cpm_size_t'(s);
      alu_dst  <= 4'(d);
      alu_a    <= a;
      alu_b    <= b;
      @(posedge ref_clk);
      alu_en   <= 1'b0;
      rd_a_idx <= 4'(d);
      cyc(1);
      m5 = (k == 4) ? 5'h1C : 5'h1F;
      chk("flags", {27'h0, e[36:32] & m5}, {27'h0, status_r[4:0] & m5});
      case (s)
        0: gp[d][7:0] = e[7:0];
        1: gp[d][15:0] = e[15:0];
        default: gp[d] = e[31:0];
      endcase
      chk("result", gp[d], rd_a_data_r);
      xf = e[36];
    end
    @(posedge ref_clk);
    wr_en    <= 1'b1;
    wr_idx   <= 4'h9;
    wr_size  <= CPM_SZ_WORD;
    wr_data  <= 32'h0000_8000;
    rd_b_idx <= 4'h9;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    cyc(1);
    chk("ptr_sext", 32'hFFFF_8000, rd_b_data_r);
    $display("test alu done");
    dbg(1'b1, CPM_RC_VBR, 32'hFFFF_FFFF);
    dbg(1'b0, CPM_RC_VBR, 32'h0000_0000);
    chk("base", 32'hFFF0_0000, rv);
    @(posedge ref_clk);
    vec_disp <= 10'h3FC;
    cyc(2);
    chk("vector", 32'hFFF0_03FC, vec_addr_r);
    @(posedge ref_clk);
    vbr_wr    <= 1'b1;
    ccr_wr    <= 1'b1;
    ctl_wdata <= 32'h1234_5615;
    @(posedge ref_clk);
    vbr_wr <= 1'b0;
    ccr_wr <= 1'b0;
    dbg(1'b0, CPM_RC_VBR, 32'h0000_0000);
    chk("base_ctl", 32'h1230_0000, rv);
    chk("flags_ctl", 32'h0000_0015, {27'h0, status_r[4:0]});
    rv = pc_r;
    @(posedge ref_clk);
    pc_adv  <= 1'b1;
    pc_step <= 3'h2;
    @(posedge ref_clk);
    pc_adv     <= 1'b1;
    pc_load    <= 1'b1;
    pc_new     <= 32'h0001_0000;
    pcrel_disp <= 32'hFFFF_FFF8;
    cyc(0);
    chk("pc_adv", rv + 32'h2, pc_r);
    @(posedge ref_clk);
    pc_adv  <= 1'b0;
    pc_load <= 1'b0;
    cyc(1);
    chk("pc_load", 32'h0001_0000, pc_r);
    chk("pc_rel", 32'h0000_FFF8, pcrel_addr_r);
    $display("test base_pc done");
    dbg(1'b1, CPM_RC_CACHE_CONTROL_WORD, 32'h1 << CPM_DSE_BIT);
    dbg(1'b1, CPM_RC_GP | 12'h00F, 32'hAAAA_0000);
    dbg(1'b1, CPM_RC_OTHSP, 32'h5555_0000);
    cyc(1);
    chk("usp_dbg", 32'h5555_0000, usp_data_r);
    for (int t = 0; t < 2; t++) begin
      @(posedge ref_clk);
      usp_wr    <= 1'b1;
      usp_wdata <= (t == 0) ? 32'h1234_5670 : 32'hDEAD_0000;
      @(posedge ref_clk);
      usp_wr <= 1'b0;
      cyc(1);
      chk("usp_move", 32'h1234_5670, usp_data_r);
      if (t == 0)
        sr(16'h0000);
    end
    @(posedge ref_clk);
    rd_a_idx <= 4'hF;
    cyc(1);
    chk("a7_user", 32'h1234_5670, rd_a_data_r);
    dbg(1'b0, CPM_RC_OTHSP, 32'h0000_0000);
    chk("other_sp", 32'hAAAA_0000, rv);
    sr(16'hB71F);
    chk("sr_user", 32'h0000_001F, {16'h0000, status_r});
    for (int t = 0; t < 2; t++) begin
      @(posedge ref_clk);
      exc_enter <= 1'b1;
      exc_irq   <= 1'b1;
      exc_lvl   <= (t == 0) ? 3'h5 : 3'h2;
      @(posedge ref_clk);
      exc_enter <= 1'b0;
      cyc(1);
      chk("exc_sr", (t == 0) ? 32'h251F : 32'h2200, {16'h0000, status_r});
      sr(16'h3700);
      chk_bit("m_set", 1'b1, status_r[CPM_SR_M]);
    end
    $display("test stack_sr done");
    for (int m = 2; m < 8; m += 5) begin
      sr(16'h2000 | 16'(m << 8));
      for (int l = 0; l < 8; l++) begin
        @(posedge ref_clk);
        irq_lvl <= 3'(l);
        cyc(2);
        chk_bit("irq_level", l > m, irq_take_r);
      end
    end
    @(posedge ref_clk);
    irq_edge7 <= 1'b1;
    @(posedge ref_clk);
    irq_edge7 <= 1'b0;
    irq_lvl   <= 3'h0;
    cyc(0);
    chk_bit("irq_edge7", 1'b1, irq_take_r);
    for (int t = 1; t >= 0; t--) begin
      sr((t == 1) ? 16'hA700 : 16'h2700);
      @(posedge ref_clk);
      instr_done <= 1'b1;
      @(posedge ref_clk);
      instr_done <= 1'b0;
      cyc(0);
      chk_bit("trace", t[0], trace_req_r);
      cyc(1);
      chk_bit("trace_end", 1'b0, trace_req_r);
    end
    dbg(1'b0, 12'h004, 32'h0000_0000);
    chk_bit("dbg_err", 1'b1, dbg_err_r);
    chk("dbg_err_data", 32'h0000_0000, rv);
    $display("test irq_trace_dbg done");
    rst_fetch(4'h3);
    sr(16'h0000);
    @(posedge ref_clk);
    rd_a_idx <= 4'hF;
    cyc(1);
    chk("single_sp", sp_val, rd_a_data_r);
    $display("test slow_reset done");
    conclude();
  end
endmodule
